// ---- ilm_pkg.sv ----
// Package for the interrupt log and interrupt merge block
package ilm_pkg;

  // Register offsets
  localparam logic [7:0]  HW_PEND_OFS     = 8'h06;   // Hardware pending interrupts
  localparam logic [7:0]  LOG_PTR_OFS     = 8'h0A;   // Log address pointer
  localparam logic [7:0]  HW_EN_OFS       = 8'h0F;   // Hardware interrupt enable
  localparam logic [7:0]  HW_OE_OFS       = 8'h13;   // Hardware interrupt output enable

  // Field positions
  localparam int          SUM_LSB         = 0;       // Summary bits 2:0
  localparam int          SUM_W           = 3;       // BC, monitor, remote terminal
  localparam int          EVT_LSB         = 3;       // Event bits 15:3
  localparam int          EVT_W           = 13;      // Width of event field
  localparam int          EN_RO_W         = 5;       // Read-only enable bits 4:0
  localparam int          PARITY_BIT      = 14;      // RAM parity fail event bit
  localparam int          SRC_HW          = 0;       // Source slot: hardware
  localparam int          SRC_BC          = 1;       // Source slot: bus controller
  localparam int          SRC_MT          = 2;       // Source slot: monitor
  localparam int          SRC_RT          = 3;       // Source slot: remote terminal
  localparam int          NSRC            = 4;       // Number of log sources

  // Log placement
  localparam logic [15:0] LOG_BASE        = 16'h0180; // First word of the log
  localparam logic [15:0] LOG_LAST_ENTRY  = 16'h01BE; // Ident word of entry 32
  localparam logic [15:0] ENTRY_STEP      = 16'h0002; // Words per entry
  localparam logic [15:0] HW_LOC_WORD     = 16'h0000; // Location word for hardware

  // Reset values
  localparam logic [15:0] HW_EN_RST       = 16'h6000; // Enable after reset
  localparam logic [15:0] HW_OE_RST       = 16'h6000; // Output enable after reset
  localparam logic [4:0]  HW_EN_RO_VAL    = 5'h00;    // Fixed read value of bits 4:0
  localparam logic [15:0] UNMAPPED_RD     = 16'h0000; // Read of an unused offset

  // One event from a terminal at message end
  typedef struct packed {
    logic [EVT_W-1:0] bits;   // Enabled events, bits 15:3 of its pending register
    logic             oe;     // At least one event has output enabled
    logic [15:0]      loc;    // Message location word
  } ilm_evt_t;

  // Register access request
  typedef struct packed {
    logic        wr;          // Write strobe
    logic        rd;          // Read strobe
    logic [7:0]  addr;        // Register offset
    logic [15:0] wdata;       // Write data
  } ilm_reg_req_t;

  // Log writer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WR_IDENT,
    ST_WR_LOC
  } ilm_state_t;

endpackage : ilm_pkg

// ---- ilm_irq_merge.sv ----
// Interrupt log writer and host interrupt merge
// Summary of operation
// - One log entry per terminal per message
// - Same-terminal events ORed into one interrupt
// - Each interrupting terminal gets its own entry
// - Different-terminal events ORed into one interrupt
// - Log spans 0x0180 to 0x01BF, ident even
// - Pointer steps two words per entry
// - After entry 32 pointer returns to base
// - Master or software reset sets pointer base
// - Enable register bits 4:0 are read-only
// - Pending bits 2:0 flag RT, monitor, BC
// - Ident word: source bit plus pending bits
// - Hardware location word zero, parity gives address
// - Summary bits follow terminal pending registers
`timescale 1ns/1ps

module ilm_irq_merge (
  input  wire logic                  sys_clk,          // System clock, 125 MHz
  input  wire logic                  resetn,           // Master reset, async, low
  input  wire logic                  soft_reset,       // Software reset pulse
  input  wire ilm_pkg::ilm_reg_req_t reg_req,          // Host register request
  input  wire ilm_pkg::ilm_evt_t     bc_evt,           // Bus controller message event
  input  wire ilm_pkg::ilm_evt_t     mt_evt,           // Monitor message event
  input  wire ilm_pkg::ilm_evt_t     rt_evt,           // Remote terminal message event
  input  wire logic [12:0]           bc_pend,          // BC pending register bits 15:3
  input  wire logic [12:0]           mt_pend,          // Monitor pending bits 15:3
  input  wire logic [12:0]           rt_pend,          // RT pending bits 15:3
  input  wire logic [12:0]           hw_evt,           // Hardware events, bits 15:3
  input  wire logic                  ram_parity_fail,  // RAM parity fail pulse
  input  wire logic [15:0]           ram_parity_addr,  // Address that failed parity
  input  wire logic                  irq_ack,          // Host acknowledge of terminal irq
  input  wire logic                  ram_ready,        // RAM accepts the write
  output logic                       ram_wr_ff,        // RAM write request
  output logic [15:0]                ram_addr_ff,      // RAM word address
  output logic [15:0]                ram_wdata_ff,     // RAM write data
  output logic [15:0]                reg_rdata_ff,     // Register read data
  output logic                       reg_rvalid_ff,    // Read data valid pulse
  output logic                       irq_out_n_ff      // Host interrupt, active low
);

  // Pending log entries, one slot per source
  logic [ilm_pkg::NSRC-1:0]   slot_vld_ff;                 // Slot holds an entry
  logic [ilm_pkg::NSRC-1:0]   nxt_slot_vld;
  logic [15:0]                slot_id_ff  [ilm_pkg::NSRC]; // Ident word per slot
  logic [15:0]                nxt_slot_id [ilm_pkg::NSRC];
  logic [15:0]                slot_loc_ff [ilm_pkg::NSRC]; // Location word per slot
  logic [15:0]                nxt_slot_loc[ilm_pkg::NSRC];

  // Writer state
  ilm_pkg::ilm_state_t        state_ff;                    // Log writer state
  ilm_pkg::ilm_state_t        nxt_state;
  logic [15:0]                cur_loc_ff;                  // Location word of entry in flight
  logic [15:0]                nxt_cur_loc;
  logic [15:0]                log_ptr_ff;                  // Log address pointer
  logic [15:0]                nxt_log_ptr;
  logic                       nxt_ram_wr;
  logic [15:0]                nxt_ram_addr;
  logic [15:0]                nxt_ram_wdata;

  // Registers and interrupt state
  logic [15:0]                hw_pend_ff;                  // Sticky hardware bits 15:3
  logic [15:0]                nxt_hw_pend;
  logic [15:0]                hw_en_ff;                    // Hardware enable, bits 15:5
  logic [15:0]                nxt_hw_en;
  logic [15:0]                hw_oe_ff;                    // Hardware output enable
  logic [15:0]                nxt_hw_oe;
  logic                       term_irq_ff;                 // Terminal interrupt latched
  logic                       nxt_term_irq;
  logic                       nxt_irq_out_n;
  logic [15:0]                nxt_reg_rdata;
  logic                       nxt_reg_rvalid;

  // Incoming events per slot
  ilm_pkg::ilm_evt_t          in_evt [ilm_pkg::NSRC];
  logic [15:0]                hw_new;                      // Enabled hardware events
  logic [2:0]                 summary;                     // Pending summary bits 2:0
  logic [1:0]                 pick;                        // Lowest waiting slot
  logic                       any_wait;                    // Some slot waits

  // Ident word from a source bit and event bits
  function automatic logic [15:0] mk_ident(input logic [2:0] src, input logic [12:0] bits);
    mk_ident = {bits, src};
  endfunction : mk_ident

  // Next pointer with wrap to the log base
  function automatic logic [15:0] step_ptr(input logic [15:0] p);
    if (p == ilm_pkg::LOG_LAST_ENTRY) begin
      step_ptr = ilm_pkg::LOG_BASE;
    end else begin
      step_ptr = p + ilm_pkg::ENTRY_STEP;
    end
  endfunction : step_ptr

  // Gather events and the summary bits
  always_comb begin
    hw_new = {hw_evt, 3'h0};
    if (ram_parity_fail) begin
      hw_new[ilm_pkg::PARITY_BIT] = 1'b1;
    end
    hw_new = hw_new & hw_en_ff;
    summary = {|rt_pend, |mt_pend, |bc_pend};
    in_evt[ilm_pkg::SRC_HW].bits = hw_new[15:3];
    in_evt[ilm_pkg::SRC_HW].oe   = |(hw_new & hw_oe_ff);
    // Hardware location word is zero unless parity failed with its enable bit set
    in_evt[ilm_pkg::SRC_HW].loc  = ram_parity_fail && hw_en_ff[ilm_pkg::PARITY_BIT]
                                   ? ram_parity_addr : ilm_pkg::HW_LOC_WORD;
    in_evt[ilm_pkg::SRC_BC]      = bc_evt;
    in_evt[ilm_pkg::SRC_MT]      = mt_evt;
    in_evt[ilm_pkg::SRC_RT]      = rt_evt;
  end

  // Pick the lowest waiting slot
  always_comb begin
    pick     = 2'h0;
    any_wait = 1'b0;
    for (int i = ilm_pkg::NSRC - 1; i >= 0; i--) begin
      if (slot_vld_ff[i]) begin
        pick     = 2'(i);
        any_wait = 1'b1;
      end
    end
  end

  // Slot fill and merge
  always_comb begin
    logic [2:0] src_bit;
    src_bit      = 3'h0;
    nxt_slot_vld = slot_vld_ff;
    nxt_slot_id  = slot_id_ff;
    nxt_slot_loc = slot_loc_ff;
    // Slot handed to the writer as its entry starts; a later event opens a new one
    if (state_ff == ilm_pkg::ST_IDLE && any_wait) begin
      nxt_slot_vld[pick] = 1'b0;
    end
    for (int i = 0; i < ilm_pkg::NSRC; i++) begin
      // Hardware ident uses the pending format, terminals their own bit
      src_bit = (i == ilm_pkg::SRC_HW) ? summary : 3'(1 << (i - 1));
      if (|in_evt[i].bits) begin
        if (nxt_slot_vld[i]) begin
          // Same source before its entry starts: merge into one entry
          nxt_slot_id[i] = slot_id_ff[i] | mk_ident(src_bit, in_evt[i].bits);
        end else begin
          // Each source keeps its own slot and entry
          nxt_slot_vld[i] = 1'b1;
          nxt_slot_id[i]  = mk_ident(src_bit, in_evt[i].bits);
          nxt_slot_loc[i] = in_evt[i].loc;
        end
      end
    end
    // Software reset drops queued entries
    if (soft_reset) begin
      nxt_slot_vld = '0;
    end
  end

  // Slot registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      slot_vld_ff <= '0;
      for (int i = 0; i < ilm_pkg::NSRC; i++) begin
        slot_id_ff[i]  <= 16'h0000;
        slot_loc_ff[i] <= 16'h0000;
      end
    end else begin
      slot_vld_ff <= nxt_slot_vld;
      slot_id_ff  <= nxt_slot_id;
      slot_loc_ff <= nxt_slot_loc;
    end
  end

  // Log writer: ident word, location word, then pointer
  always_comb begin
    nxt_state     = state_ff;
    nxt_cur_loc   = cur_loc_ff;
    nxt_log_ptr   = log_ptr_ff;
    nxt_ram_wr    = ram_wr_ff;
    nxt_ram_addr  = ram_addr_ff;
    nxt_ram_wdata = ram_wdata_ff;
    unique case (state_ff)
      ilm_pkg::ST_IDLE: begin
        if (any_wait) begin
          // Ident word on the even address
          nxt_cur_loc   = slot_loc_ff[pick];
          nxt_ram_wr    = 1'b1;
          nxt_ram_addr  = log_ptr_ff;
          nxt_ram_wdata = slot_id_ff[pick];
          nxt_state     = ilm_pkg::ST_WR_IDENT;
        end
      end
      ilm_pkg::ST_WR_IDENT: begin
        if (ram_ready) begin
          // Location word on the odd address next
          nxt_ram_addr  = log_ptr_ff + 16'h0001;
          nxt_ram_wdata = cur_loc_ff;
          nxt_state     = ilm_pkg::ST_WR_LOC;
        end else begin
          // Stalled ident word stays put until the RAM takes it
          nxt_ram_wdata = ram_wdata_ff;
        end
      end
      ilm_pkg::ST_WR_LOC: begin
        if (ram_ready) begin
          // Pointer moves only after both words are written
          nxt_ram_wr  = 1'b0;
          nxt_log_ptr = step_ptr(log_ptr_ff);
          nxt_state   = ilm_pkg::ST_IDLE;
        end
      end
    endcase
    // Software reset returns the pointer to the base
    if (soft_reset) begin
      nxt_state   = ilm_pkg::ST_IDLE;
      nxt_ram_wr  = 1'b0;
      nxt_log_ptr = ilm_pkg::LOG_BASE;
    end
  end

  // Writer registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff     <= ilm_pkg::ST_IDLE;
      cur_loc_ff   <= 16'h0000;
      log_ptr_ff   <= ilm_pkg::LOG_BASE;
      ram_wr_ff    <= 1'b0;
      ram_addr_ff  <= 16'h0000;
      ram_wdata_ff <= 16'h0000;
    end else begin
      state_ff     <= nxt_state;
      cur_loc_ff   <= nxt_cur_loc;
      log_ptr_ff   <= nxt_log_ptr;
      ram_wr_ff    <= nxt_ram_wr;
      ram_addr_ff  <= nxt_ram_addr;
      ram_wdata_ff <= nxt_ram_wdata;
    end
  end

  // Registers, interrupt merge and read path
  always_comb begin
    logic term_oe_hit;
    term_oe_hit    = 1'b0;
    nxt_hw_pend    = hw_pend_ff;
    nxt_hw_en      = hw_en_ff;
    nxt_hw_oe      = hw_oe_ff;
    nxt_reg_rdata  = reg_rdata_ff;
    nxt_reg_rvalid = 1'b0;
    // Host writes
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        ilm_pkg::HW_PEND_OFS: nxt_hw_pend = hw_pend_ff & ~reg_req.wdata;   // Write 1 clears
        ilm_pkg::HW_EN_OFS: begin
          // Low five bits are not host writable
          nxt_hw_en = {reg_req.wdata[15:ilm_pkg::EN_RO_W], ilm_pkg::HW_EN_RO_VAL};
        end
        ilm_pkg::HW_OE_OFS:   nxt_hw_oe = {reg_req.wdata[15:3], 3'h0};
        default: ;                                                          // Writes ignored
      endcase
    end
    // New hardware events win over a clear in the same cycle
    nxt_hw_pend = nxt_hw_pend | hw_new;
    // Any output-enabled terminal event, BC, monitor and RT ORed
    for (int i = ilm_pkg::SRC_BC; i < ilm_pkg::NSRC; i++) begin
      term_oe_hit = term_oe_hit | (|in_evt[i].bits & in_evt[i].oe);
    end
    // Latched until acknowledged; a new event beats the acknowledge
    nxt_term_irq = (term_irq_ff & ~irq_ack) | term_oe_hit;
    // One low level for all enabled sources together
    nxt_irq_out_n = ~(nxt_term_irq | (|(nxt_hw_pend & hw_oe_ff)));
    // Host reads
    if (reg_req.rd) begin
      nxt_reg_rvalid = 1'b1;
      unique case (reg_req.addr)
        ilm_pkg::HW_PEND_OFS: nxt_reg_rdata = {hw_pend_ff[15:3], summary};
        ilm_pkg::LOG_PTR_OFS: nxt_reg_rdata = log_ptr_ff;
        ilm_pkg::HW_EN_OFS:   nxt_reg_rdata = {hw_en_ff[15:5], ilm_pkg::HW_EN_RO_VAL};
        ilm_pkg::HW_OE_OFS:   nxt_reg_rdata = hw_oe_ff;
        default:              nxt_reg_rdata = ilm_pkg::UNMAPPED_RD;
      endcase
    end
  end

  // Register and interrupt flops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hw_pend_ff    <= 16'h0000;
      hw_en_ff      <= ilm_pkg::HW_EN_RST;
      hw_oe_ff      <= ilm_pkg::HW_OE_RST;
      term_irq_ff   <= 1'b0;
      irq_out_n_ff  <= 1'b1;
      reg_rdata_ff  <= 16'h0000;
      reg_rvalid_ff <= 1'b0;
    end else begin
      hw_pend_ff    <= nxt_hw_pend;
      hw_en_ff      <= nxt_hw_en;
      hw_oe_ff      <= nxt_hw_oe;
      term_irq_ff   <= nxt_term_irq;
      irq_out_n_ff  <= nxt_irq_out_n;
      reg_rdata_ff  <= nxt_reg_rdata;
      reg_rvalid_ff <= nxt_reg_rvalid;
    end
  end

endmodule : ilm_irq_merge

// ---- ilm_irq_merge_sva.sv ----
// Property checker for the interrupt log writer and interrupt merge
`timescale 1ns/1ps
module ilm_irq_merge_sva (
  input wire logic                  sys_clk,        // Clock
  input wire logic                  resetn,         // Reset, low
  input wire logic                  soft_reset,     // Software reset
  input wire ilm_pkg::ilm_reg_req_t reg_req,        // Register request
  input wire ilm_pkg::ilm_evt_t     rt_evt,         // RT event
  input wire logic [12:0]           rt_pend,        // RT pending level
  input wire logic                  irq_ack,        // Irq acknowledge
  input wire logic                  ram_ready,      // RAM takes word
  input wire logic                  ram_wr_ff,      // RAM write
  input wire logic [15:0]           ram_addr_ff,    // RAM address
  input wire logic [15:0]           ram_wdata_ff,   // RAM data
  input wire logic [15:0]           reg_rdata_ff,   // Read data
  input wire logic                  reg_rvalid_ff,  // Read valid
  input wire logic                  irq_out_n_ff    // Interrupt, low
);
  default clocking @(posedge sys_clk);
  endclocking
  // Soft reset aborts the writer, so no log check spans it
  default disable iff (!resetn || soft_reset);
  // Ident word handed over at an even address
  sequence s_id_taken;
    ram_wr_ff && ram_ready && !ram_addr_ff[0];
  endsequence
  // Location word handed over at an odd address
  sequence s_loc_taken;
    ram_wr_ff && ram_ready && ram_addr_ff[0];
  endsequence
  a_log_range: assert property (ram_wr_ff |-> ram_addr_ff >= 16'h0180 && ram_addr_ff <= 16'h01BF)
    else $error("log write outside its window");
  a_req_held: assert property (ram_wr_ff && !ram_ready |=>
    ram_wr_ff && $stable(ram_addr_ff) && $stable(ram_wdata_ff))
    else $error("stalled RAM write changed");
  a_id_then_loc: assert property (s_id_taken |=>
    ram_wr_ff && ram_addr_ff == $past(ram_addr_ff) + 16'h0001)
    else $error("location word did not follow ident");
  a_loc_then_gap: assert property (s_loc_taken |=> !ram_wr_ff)
    else $error("no idle cycle after entry");
  a_ptr_step: assert property (s_loc_taken ##1 !ram_wr_ff ##1 ram_wr_ff |->
    ram_addr_ff == (($past(ram_addr_ff, 2) == 16'h01BF) ? 16'h0180
                    : $past(ram_addr_ff, 2) + 16'h0001))
    else $error("next entry at wrong address");
  a_evt_to_wr: assert property (rt_evt.bits != 13'h0000 |-> ##[1:12] ram_wr_ff)
    else $error("event not logged in time");
  a_irq_rt: assert property (rt_evt.bits != 13'h0000 && rt_evt.oe |=> !irq_out_n_ff)
    else $error("enabled event did not raise irq");
  a_irq_latch: assert property (!irq_out_n_ff && !irq_ack && !reg_req.wr |=> !irq_out_n_ff)
    else $error("irq released without cause");
  a_en_ro: assert property (reg_rvalid_ff && $past(reg_req.addr) == ilm_pkg::HW_EN_OFS |->
    reg_rdata_ff[4:0] == 5'h00)
    else $error("enable low bits not zero");
  a_pend_sum: assert property (reg_rvalid_ff && $past(reg_req.addr) == ilm_pkg::HW_PEND_OFS |->
    reg_rdata_ff[2] == (|$past(rt_pend)))
    else $error("RT summary bit wrong");
endmodule : ilm_irq_merge_sva

bind ilm_irq_merge ilm_irq_merge_sva u_sva (
  .sys_clk, .resetn, .soft_reset, .reg_req, .rt_evt, .rt_pend, .irq_ack,
  .ram_ready, .ram_wr_ff, .ram_addr_ff, .ram_wdata_ff, .reg_rdata_ff,
  .reg_rvalid_ff, .irq_out_n_ff
);

// ---- ilm_ram_model.sv ----
// Shared RAM model that takes the log writes
`timescale 1ns/1ps
module ilm_ram_model (
  input  wire logic        sys_clk,       // Clock
  input  wire logic        resetn,        // Reset, low
  input  wire logic        slow,          // Stall every other cycle
  input  wire logic        ram_wr_ff,     // Write request
  input  wire logic [15:0] ram_addr_ff,   // Word address
  input  wire logic [15:0] ram_wdata_ff,  // Write data
  output logic             ram_ready      // Word taken
);
  logic [15:0] mem [0:511];  // Log window and neighbours
  logic        ph_ff;        // Stall phase
  // Phase toggles freely; slow mode holds ram_ready low on every other cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) ph_ff <= 1'b0;
    else ph_ff <= ~ph_ff;
  end
  assign ram_ready = !slow || ph_ff;
  // Store only words the handshake accepted
  always_ff @(posedge sys_clk) begin
    if (ram_wr_ff && ram_ready) mem[ram_addr_ff[8:0]] <= ram_wdata_ff;
  end
endmodule : ilm_ram_model

// ---- tb.sv ----
// Self-checking bench for the interrupt log writer and merge
`timescale 1ns/1ps
module tb;
  logic                  sys_clk, resetn, soft_reset, irq_ack;  // Clock and controls
  logic                  ram_parity_fail, ram_ready, slow;      // Parity pulse, RAM side
  logic                  ram_wr_ff, reg_rvalid_ff, irq_out_n_ff; // Design outputs
  logic [12:0]           bc_pend, mt_pend, rt_pend, hw_evt;     // Pending levels, hw events
  logic [15:0]           ram_addr_ff, ram_wdata_ff, reg_rdata_ff; // Design words
  logic [15:0]           ram_parity_addr, exp_ptr;              // Parity address, model ptr
  ilm_pkg::ilm_reg_req_t reg_req;                               // Register request
  ilm_pkg::ilm_evt_t     bc_evt, mt_evt, rt_evt;                // Terminal events
  int                    num_errors = 0, n_checks = 0, n_irq = 0, cyc = 0; // Counters
  ilm_irq_merge DUT (
    .sys_clk, .resetn, .soft_reset, .reg_req, .bc_evt, .mt_evt, .rt_evt,
    .bc_pend, .mt_pend, .rt_pend, .hw_evt, .ram_parity_fail, .ram_parity_addr,
    .irq_ack, .ram_ready, .ram_wr_ff, .ram_addr_ff, .ram_wdata_ff,
    .reg_rdata_ff, .reg_rvalid_ff, .irq_out_n_ff
  );
  ilm_ram_model u_ram (
    .sys_clk, .resetn, .slow, .ram_wr_ff, .ram_addr_ff, .ram_wdata_ff, .ram_ready
  );
  // Clock, 8 ns period
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Count irq assertions so merged events show as one
  always @(negedge irq_out_n_ff) n_irq++;
  // Hang guard, far above the few hundred cycles needed
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    reg_req <= '0;
  endtask : reg_wr
  // Read answer lands one cycle after the request edge
  task automatic reg_rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge sys_clk);
    reg_req <= '0;
    @(negedge sys_clk);
    chk("read valid", 16'h0001, {15'h0000, reg_rvalid_ff});
    chk("register read", e, reg_rdata_ff);
  endtask : reg_rd
  // Wait until the writer has been idle for four cycles
  task automatic settle;
    int q;
    q = 0;
    for (int i = 0; i < 60 && q < 4; i++) begin
      @(posedge sys_clk);
      q = ram_wr_ff ? 0 : q + 1;
    end
  endtask : settle
  // Compare one entry at the expected pointer, then step it
  task automatic log_chk(input logic [15:0] id, input logic [15:0] lw);
    chk("log ident word", id, u_ram.mem[exp_ptr[8:0]]);
    chk("log location word", lw, u_ram.mem[exp_ptr[8:0] + 9'h001]);
    exp_ptr = (exp_ptr == ilm_pkg::LOG_LAST_ENTRY) ? ilm_pkg::LOG_BASE
              : exp_ptr + ilm_pkg::ENTRY_STEP;
  endtask : log_chk
  task automatic ack;
    @(posedge sys_clk);
    irq_ack <= 1'b1;
    @(posedge sys_clk);
    irq_ack <= 1'b0;
    @(negedge sys_clk);
    chk("irq after ack", 16'h0001, {15'h0000, irq_out_n_ff});
  endtask : ack
  // Reset values, read-only enable bits, unmapped offset
  task automatic t_regs;
    reg_rd(ilm_pkg::LOG_PTR_OFS, ilm_pkg::LOG_BASE);
    reg_rd(ilm_pkg::HW_EN_OFS, ilm_pkg::HW_EN_RST);
    reg_rd(ilm_pkg::HW_OE_OFS, ilm_pkg::HW_OE_RST);
    reg_rd(8'h55, ilm_pkg::UNMAPPED_RD);
    reg_wr(ilm_pkg::HW_EN_OFS, 16'hFFFF);
    reg_rd(ilm_pkg::HW_EN_OFS, 16'hFFE0);
    reg_wr(ilm_pkg::HW_EN_OFS, ilm_pkg::HW_EN_RST);
  endtask : t_regs
  // Two events of one terminal: one entry, one irq
  task automatic t_one;
    int n0;
    n0 = n_irq;
    @(posedge sys_clk);
    rt_evt <= '{13'h0005, 1'b1, 16'h0C40};
    @(posedge sys_clk);
    rt_evt <= '0;
    settle();
    log_chk({13'h0005, 3'b100}, 16'h0C40);
    chk("irq count", 16'(n0 + 1), 16'(n_irq));
    ack();
  endtask : t_one
  // Three terminals at once on a stalling RAM
  task automatic t_multi;
    int n0;
    n0 = n_irq;
    @(posedge sys_clk);
    slow <= 1'b1;
    bc_evt <= '{13'h0003, 1'b1, 16'h0A00};
    mt_evt <= '{13'h0010, 1'b0, 16'h0B00};
    rt_evt <= '{13'h1001, 1'b1, 16'h0C00};
    @(posedge sys_clk);
    {bc_evt, mt_evt, rt_evt} <= '0;
    settle();
    slow <= 1'b0;
    log_chk({13'h0003, 3'b001}, 16'h0A00);
    log_chk({13'h0010, 3'b010}, 16'h0B00);
    log_chk({13'h1001, 3'b100}, 16'h0C00);
    chk("irq count", 16'(n0 + 1), 16'(n_irq));
    ack();
  endtask : t_multi
  // Hardware events, parity address, summary bits, clearing
  task automatic t_hw;
    @(posedge sys_clk);
    hw_evt <= 13'h0400;
    ram_parity_fail <= 1'b1;
    ram_parity_addr <= 16'h0123;
    @(posedge sys_clk);
    hw_evt <= 13'h0000;
    ram_parity_fail <= 1'b0;
    settle();
    log_chk({13'h0C00, 3'b000}, 16'h0123);
    hw_evt <= 13'h0400;
    @(posedge sys_clk);
    hw_evt <= 13'h0000;
    settle();
    log_chk({13'h0400, 3'b000}, ilm_pkg::HW_LOC_WORD);
    chk("irq from hw", 16'h0000, {15'h0000, irq_out_n_ff});
    bc_pend <= 13'h0001;
    rt_pend <= 13'h0100;
    reg_rd(ilm_pkg::HW_PEND_OFS, 16'h6005);
    reg_wr(ilm_pkg::HW_PEND_OFS, 16'h6000);
    {bc_pend, rt_pend} <= '0;
    reg_rd(ilm_pkg::HW_PEND_OFS, 16'h0000);
    chk("irq cleared", 16'h0001, {15'h0000, irq_out_n_ff});
  endtask : t_hw
  // Software reset mid-log: next entry lands at the base
  task automatic t_soft;
    reg_rd(ilm_pkg::LOG_PTR_OFS, exp_ptr);
    @(posedge sys_clk);
    soft_reset <= 1'b1;
    @(posedge sys_clk);
    soft_reset <= 1'b0;
    exp_ptr = ilm_pkg::LOG_BASE;
    reg_rd(ilm_pkg::LOG_PTR_OFS, ilm_pkg::LOG_BASE);
    @(posedge sys_clk);
    mt_evt <= '{13'h0002, 1'b0, 16'h0B10};
    @(posedge sys_clk);
    mt_evt <= '0;
    settle();
    log_chk({13'h0002, 3'b010}, 16'h0B10);
  endtask : t_soft
  // Run past entry 32 so the log wraps to its base
  task automatic t_wrap;
    for (int i = 0; i < 32; i++) begin
      @(posedge sys_clk);
      bc_evt <= '{13'(i + 1), 1'b0, 16'(16'h0D00 + i)};
      @(posedge sys_clk);
      bc_evt <= '0;
      settle();
      log_chk({13'(i + 1), 3'b001}, 16'(16'h0D00 + i));
    end
    reg_rd(ilm_pkg::LOG_PTR_OFS, exp_ptr);
  endtask : t_wrap
  task automatic final_report;
    if (num_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  // Reset for twelve cycles, then every scenario in turn
  initial begin
    {resetn, soft_reset, irq_ack, ram_parity_fail, slow} = '0;
    {bc_pend, mt_pend, rt_pend, hw_evt} = '0;
    {reg_req, bc_evt, mt_evt, rt_evt} = '0;
    ram_parity_addr = 16'h0000;
    exp_ptr = ilm_pkg::LOG_BASE;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    t_regs();
    t_one();
    t_multi();
    t_hw();
    t_soft();
    t_wrap();
    final_report();
  end
endmodule : tb
